// File: core/tsq_pkg.sv
// Package of constants and carrier types for the trigger sequencer step timing block
package tsq_pkg;
   // ***************************************************************
   // Register map (byte addresses)
   // ***************************************************************
   localparam logic [7:0]  TSQ_OFF_CTRL    = 8'h00;
   localparam logic [7:0]  TSQ_OFF_BTE     = 8'h04;
   localparam logic [7:0]  TSQ_OFF_SDLIM   = 8'h08;
   localparam logic [7:0]  TSQ_OFF_C0LIM   = 8'h0c;
   localparam logic [7:0]  TSQ_OFF_STATUS  = 8'h10;
   // ***************************************************************
   // Field positions and reset values
   // ***************************************************************
   localparam int          TSQ_CTRL_EN_BIT   = 0;
   localparam int          TSQ_CTRL_STRT_BIT = 1;
   localparam int          TSQ_BTE_TRIG_LSB  = 0;
   localparam int          TSQ_BTE_CLK_BIT   = 4;
   localparam int          TSQ_STAT_BUSY_BIT = 0;
   localparam int          TSQ_STAT_C0_LSB   = 16;
   localparam logic [15:0] TSQ_LIM_RESET     = 16'h0000;
   localparam logic [4:0]  TSQ_BTE_RESET     = 5'h00;
   localparam logic [1:0]  TSQ_CTRL_RESET    = 2'h0;
   localparam logic [3:0]  TSQ_OPT_BROADCAST = 4'hf;
   localparam int          TSQ_NUM_OC        = 4;
   localparam int          TSQ_BASE_DELAY    = 1;

   typedef enum logic [1:0] {
      TSQ_CMD_CTRL  = 2'h0,
      TSQ_CMD_JMPC0 = 2'h1,
      TSQ_CMD_OTHER = 2'h2
   } tsq_cmd_e;

   typedef enum logic [1:0] {
      TSQ_ST_IDLE  = 2'b00,
      TSQ_ST_DELAY = 2'b01
   } tsq_state_e;

   typedef struct packed {
      tsq_cmd_e   kind;
      logic [3:0] option;
   } tsq_step_cmd_s;

   typedef struct packed {
      logic                  oc1_clk;
      logic [TSQ_NUM_OC-1:0] oc_trig;
   } tsq_bcast_s;
endpackage

// File: core/tsq_step_timing.sv
// Trigger sequencer step timing, broadcast fan-out and counter 0 with APB registers
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module tsq_step_timing #(
   parameter int LIM_W = 16
) (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   seq_tick,
   input  wire logic                   step_valid,
   input  wire tsq_pkg::tsq_step_cmd_s step_cmd,
   output logic                        step_ready,
   output logic                        step_done,
   output logic                        jump_taken,
   output logic                        counter0_at_limit,
   output tsq_pkg::tsq_bcast_s         bcast
);
   import tsq_pkg::*;

   if (LIM_W < 1 || LIM_W > 16) begin : g_chk
      $error("LIM_W must be 1..16");
   end

   // ***************************************************************
   // APB decode
   // ***************************************************************
   logic [1:0]             ctrl_q;
   logic [4:0]             bte_q;
   logic [LIM_W-1:0]       sdlim_q;
   logic [LIM_W-1:0]       c0lim_q;
   logic [LIM_W-1:0]       c0cnt_q;
   logic [LIM_W-1:0]       dly_q;
   tsq_state_e             state_q;
   logic                   done_q;
   logic                   jump_q;
   tsq_bcast_s             bcast_q;

   wire        access    = psel && penable;
   wire        wr        = access && pwrite;
   wire        hit_ctrl  = paddr == TSQ_OFF_CTRL;
   wire        hit_bte   = paddr == TSQ_OFF_BTE;
   wire        hit_sdlim = paddr == TSQ_OFF_SDLIM;
   wire        hit_c0lim = paddr == TSQ_OFF_C0LIM;
   wire        hit_stat  = paddr == TSQ_OFF_STATUS;
   wire        mapped    = hit_ctrl || hit_bte || hit_sdlim || hit_c0lim || hit_stat;
   wire        running   = ctrl_q[TSQ_CTRL_EN_BIT] && ctrl_q[TSQ_CTRL_STRT_BIT];
   wire        locked    = running;
   wire        wr_open   = wr && !locked;
   wire        busy      = state_q == TSQ_ST_DELAY;
   wire        accept    = step_valid && step_ready;
   wire        is_bcast  = step_cmd.kind == TSQ_CMD_CTRL && step_cmd.option == TSQ_OPT_BROADCAST;
   wire        step_end  = busy && seq_tick && dly_q == sdlim_q;
   wire        c0_full   = c0cnt_q == c0lim_q;
   wire [31:0] rd_ctrl   = {30'h0, ctrl_q};
   wire [31:0] rd_bte    = {27'h0, bte_q};
   wire [31:0] rd_sdlim  = 32'(sdlim_q);
   wire [31:0] rd_c0lim  = 32'(c0lim_q);
   wire [31:0] rd_stat   = (32'(c0cnt_q) << TSQ_STAT_C0_LSB) | (32'(busy) << TSQ_STAT_BUSY_BIT);
   wire [31:0] rd_mux    = hit_ctrl  ? rd_ctrl  :
                           hit_bte   ? rd_bte   :
                           hit_sdlim ? rd_sdlim :
                           hit_c0lim ? rd_c0lim :
                           hit_stat  ? rd_stat  : 32'h0;

   assign pready            = 1'b1;
   assign pslverr           = access && !mapped;
   assign prdata            = rd_mux;
   assign step_ready        = running && !busy;
   assign step_done         = done_q;
   assign jump_taken        = jump_q;
   assign counter0_at_limit = c0_full;
   assign bcast             = bcast_q;

   // ***************************************************************
   // Registers
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q  <= TSQ_CTRL_RESET;
         bte_q   <= TSQ_BTE_RESET;
         sdlim_q <= LIM_W'(TSQ_LIM_RESET);
         c0lim_q <= LIM_W'(TSQ_LIM_RESET);
      end else begin
         if (wr && hit_ctrl) begin
            ctrl_q <= pwdata[1:0];
         end
         if (wr_open && hit_bte) begin
            bte_q <= pwdata[4:0];
         end
         if (wr_open && hit_sdlim) begin
            sdlim_q <= pwdata[LIM_W-1:0];
         end
         if (wr_open && hit_c0lim) begin
            c0lim_q <= pwdata[LIM_W-1:0];
         end
      end
   end

   // ***************************************************************
   // Step timing
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= TSQ_ST_IDLE;
         dly_q   <= '0;
         done_q  <= 1'b0;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            TSQ_ST_IDLE: begin
               dly_q <= '0;
               if (accept) begin
                  state_q <= TSQ_ST_DELAY;
               end
            end
            TSQ_ST_DELAY: begin
               if (!running) begin
                  state_q <= TSQ_ST_IDLE;
               end else if (step_end) begin
                  state_q <= TSQ_ST_IDLE;
                  done_q  <= 1'b1;
               end else if (seq_tick) begin
                  dly_q <= dly_q + 1'b1;
               end
            end
            default: begin
               state_q <= TSQ_ST_IDLE;
            end
         endcase
      end
   end

   // ***************************************************************
   // Counter 0 and jump decision
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         c0cnt_q <= '0;
         jump_q  <= 1'b0;
      end else if (accept && step_cmd.kind == TSQ_CMD_JMPC0) begin
         c0cnt_q <= c0_full ? '0 : c0cnt_q + 1'b1;
         jump_q  <= !c0_full;
      end
   end

   // ***************************************************************
   // Broadcast fan-out
   // ***************************************************************
   wire [TSQ_NUM_OC-1:0] trig_d;
   wire                  oc1_clk_d = accept && is_bcast && bte_q[TSQ_BTE_CLK_BIT];

   for (genvar i = 0; i < TSQ_NUM_OC; i++) begin : g_trig
      assign trig_d[i] = accept && is_bcast && bte_q[TSQ_BTE_TRIG_LSB+i];
   end

   // One process owns the whole pulse word, so no bit has two drivers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bcast_q <= '0;
      end else begin
         bcast_q <= '{oc1_clk: oc1_clk_d, oc_trig: trig_d};
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   logic [LIM_W:0] obs_ticks_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         obs_ticks_q <= '0;
      end else if (accept) begin
         obs_ticks_q <= '0;
      end else if (busy && seq_tick) begin
         obs_ticks_q <= obs_ticks_q + 1'b1;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_bcast_go;
      accept && is_bcast;
   endsequence

   sequence s_locked_write(hit);
      locked && wr && hit;
   endsequence

   chk_oc1_clk_on: assert property (s_bcast_go ##0 bte_q[TSQ_BTE_CLK_BIT] |=> bcast.oc1_clk)
      else $error("oc1 clock pulse missing");
   chk_oc1_clk_cause: assert property (bcast.oc1_clk |-> $past(accept && is_bcast))
      else $error("oc1 clock pulse without broadcast");
   chk_trig_gating: assert property (s_bcast_go
                                     |=> bcast.oc_trig == $past(bte_q[TSQ_BTE_TRIG_LSB +: TSQ_NUM_OC]))
      else $error("trigger pulses differ from enables");
   chk_other_quiet: assert property (accept && !is_bcast |=> bcast == '0)
      else $error("pulse on non-broadcast step");
   chk_sdlim_locked: assert property (s_locked_write(hit_sdlim) |=> $stable(sdlim_q))
      else $error("locked delay limit changed");
   chk_bte_locked: assert property (s_locked_write(hit_bte) |=> $stable(bte_q))
      else $error("locked broadcast enables changed");
   chk_step_length: assert property (step_done
                                     |-> obs_ticks_q == (LIM_W+1)'(sdlim_q) + (LIM_W+1)'(TSQ_BASE_DELAY))
      else $error("step length is not limit plus one");
   chk_jump_wrap: assert property (accept && step_cmd.kind == TSQ_CMD_JMPC0 && c0_full
                                   |=> !jump_taken && c0cnt_q == '0)
      else $error("counter 0 did not wrap at limit");
   chk_limit_write: assert property (wr_open && hit_c0lim |=> c0lim_q == $past(pwdata[LIM_W-1:0]))
      else $error("open write to counter 0 limit lost");
endmodule

// File: test/tsq_oc_model.sv
// Output compare receivers that count broadcast pulses per channel
`timescale 1ns/1ps
module tsq_oc_model (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire tsq_pkg::tsq_bcast_s bcast,
   output logic [4:0][2:0]          pulses
);
   import tsq_pkg::*;
   logic [4:0] b;
   assign b = bcast;
   // A pulse held two cycles counts twice, so stretched pulses show up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulses <= '0;
      end else begin
         for (int i = 0; i < 5; i++) begin
            pulses[i] <= pulses[i] + 3'(b[i]);
         end
      end
   end
endmodule

// File: test/trigger_sequencer_step_timing_test.sv
// Self-checking bench for the trigger sequencer step timing block
`timescale 1ns/1ps
module trigger_sequencer_step_timing_test;
   import tsq_pkg::*;
   typedef struct packed {
      logic [1:0]  ctrl;
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic [31:0] exp;
   } tsq_row_s;
   logic            pclk, presetn, psel, penable, pwrite, seq_tick, step_valid;
   logic            pready, pslverr, err, step_ready, step_done, jump_taken, at_lim;
   logic [7:0]      paddr;
   logic [31:0]     pwdata, prdata, rd;
   tsq_step_cmd_s   step_cmd;
   tsq_bcast_s      bcast;
   logic [4:0][2:0] pulses;
   int              n_mismatch = 0;
   int              tests_run = 0;
   int              n;
   tsq_row_s        rows[8] = '{
      '{2'h0, TSQ_OFF_SDLIM, 32'hffff_1234, 32'h0000_1234},
      '{2'h0, TSQ_OFF_C0LIM, 32'h0000_ffff, 32'h0000_ffff},
      '{2'h0, TSQ_OFF_BTE, 32'hffff_ffff, 32'h0000_001f},
      '{2'h3, TSQ_OFF_SDLIM, 32'h0000_5555, 32'h0000_1234},
      '{2'h3, TSQ_OFF_C0LIM, 32'h0000_0000, 32'h0000_ffff},
      '{2'h3, TSQ_OFF_BTE, 32'h0000_0000, 32'h0000_001f},
      '{2'h1, TSQ_OFF_SDLIM, 32'h0000_0003, 32'h0000_0003},
      '{2'h2, TSQ_OFF_C0LIM, 32'h0000_0007, 32'h0000_0007}};

   tsq_step_timing u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .seq_tick(seq_tick),
      .step_valid(step_valid), .step_cmd(step_cmd), .step_ready(step_ready),
      .step_done(step_done), .jump_taken(jump_taken),
      .counter0_at_limit(at_lim), .bcast(bcast));

   tsq_oc_model u_oc (.pclk(pclk), .presetn(presetn), .bcast(bcast), .pulses(pulses));

   // ***************************************************************
   // Shared tasks
   // ***************************************************************
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Counts edges from acceptance to the edge that sees step_done
   task automatic step(input tsq_step_cmd_s c);
      step_valid <= 1'b1;
      step_cmd   <= c;
      do @(posedge pclk); while (step_ready !== 1'b1);
      step_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (step_done !== 1'b1);
   endtask

   task automatic final_report;
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ***************************************************************
   // Clock, watchdog and sequence
   // ***************************************************************
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   initial begin
      repeat (5000) @(posedge pclk);
      n_mismatch++;
      final_report;
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      seq_tick = 1'b1;
      step_valid = 1'b0;
      step_cmd = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rows[i]) begin
         apb(1'b1, TSQ_OFF_CTRL, 32'(rows[i].ctrl));
         apb(1'b1, rows[i].addr, rows[i].wdata);
         apb(1'b0, rows[i].addr, 32'h0);
         chk("register", rd, rows[i].exp);
      end
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped error", 32'(err), 32'h1);
      chk("unmapped data", rd, 32'h0);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("ready after reset", 32'(step_ready), 32'h0);
      chk("limit flag after reset", 32'(at_lim), 32'h1);
      chk("pulses after reset", 32'(pulses), 32'h0);
      apb(1'b0, TSQ_OFF_SDLIM, 32'h0);
      chk("delay limit reset", rd, 32'(TSQ_LIM_RESET));
      apb(1'b0, TSQ_OFF_C0LIM, 32'h0);
      chk("counter limit reset", rd, 32'(TSQ_LIM_RESET));
      apb(1'b1, TSQ_OFF_SDLIM, 32'h3);
      apb(1'b1, TSQ_OFF_BTE, 32'h15);
      apb(1'b1, TSQ_OFF_C0LIM, 32'h1);
      apb(1'b1, TSQ_OFF_CTRL, 32'h3);
      step('{TSQ_CMD_CTRL, TSQ_OPT_BROADCAST});
      chk("step cycles", 32'(n), 32'd5);
      chk("oc pulses", 32'(pulses), 32'h1041);
      step('{TSQ_CMD_CTRL, 4'he});
      chk("plain step pulses", 32'(pulses), 32'h1041);
      chk("plain step cycles", 32'(n), 32'd5);
      step('{TSQ_CMD_OTHER, TSQ_OPT_BROADCAST});
      chk("other step pulses", 32'(pulses), 32'h1041);
      chk("other step cycles", 32'(n), 32'd5);
      step('{TSQ_CMD_JMPC0, 4'h0});
      chk("first jump", 32'(jump_taken), 32'h1);
      chk("counter at limit", 32'(at_lim), 32'h1);
      apb(1'b0, TSQ_OFF_STATUS, 32'h0);
      chk("status count", rd, 32'h0001_0000);
      step('{TSQ_CMD_JMPC0, 4'h0});
      chk("loop exit", 32'(jump_taken), 32'h0);
      final_report;
   end
endmodule
